// ===== btc_pkg.sv
/*
 * btc_pkg: constants and types for the buffered 16-bit timer with capture and compare.
 * Assumes a word-indexed register port with 16-bit data and one synchronous clock.
 */
package btc_pkg;
    localparam int CNT_W = 16;
    localparam int NCH = 4;
    localparam int NEV = 8;
    localparam int ADDR_W = 5;

    // register word indices
    localparam logic [4:0] A_CLKSEL = 5'h00;
    localparam logic [4:0] A_MODE = 5'h01;
    localparam logic [4:0] A_EVCTL = 5'h02;
    localparam logic [4:0] A_DIR = 5'h03;
    localparam logic [4:0] A_STATUS = 5'h04;
    localparam logic [4:0] A_CNT = 5'h05;
    localparam logic [4:0] A_PER = 5'h06;
    localparam logic [4:0] A_PERIOD_BUFFER = 5'h07;
    localparam logic [4:0] A_CC0 = 5'h08;
    localparam logic [4:0] A_CCBUF0 = 5'h0C;

    // field positions
    localparam int F_WGMODE = 0;
    localparam int F_CCEN = 4;
    localparam int F_EVSEL = 0;
    localparam int F_EVDLY = 4;
    localparam int F_EVACT = 5;
    localparam int S_OVF = 0;
    localparam int S_ERR = 1;
    localparam int S_CCIF = 2;
    localparam int S_PERBV = 6;
    localparam int S_CCBV = 7;

    // reset values and capture polarity limit
    localparam logic [15:0] PER_RST = 16'hFFFF;
    localparam logic [15:0] POL_LIMIT = 16'h8000;
    localparam logic [3:0] CLK_OFF = 4'h0;

    // prescaler masks for clock selects 1..7 (divide 1,2,4,8,64,256,1024)
    localparam logic [9:0] PRE_MASK [8] = '{10'h000, 10'h000, 10'h001, 10'h003,
                                            10'h007, 10'h03F, 10'h0FF, 10'h3FF};

    typedef enum logic [2:0] {
        BTC_WG_NORMAL = 3'h0,
        BTC_WG_FRQ = 3'h1,
        BTC_WG_SS = 3'h3,
        BTC_WG_DS = 3'h5
    } btc_wg_e;

    typedef enum logic [2:0] {
        BTC_EA_OFF = 3'h0,
        BTC_EA_CAPT = 3'h1,
        BTC_EA_UPDOWN = 3'h2,
        BTC_EA_FRQ = 3'h5,
        BTC_EA_PW = 3'h6
    } btc_evact_e;

    typedef struct packed {
        logic [3:0] clksel;
        btc_wg_e wgmode;
        logic [NCH-1:0] ccen;
        btc_evact_e evact;
        logic evdly;
        logic [2:0] evsel;
        logic dir_down;
    } btc_ctrl_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [CNT_W-1:0] wdata;
        logic wr;
        logic rd;
    } btc_bus_s;
endpackage

// ===== btc_timer.sv
/*
 * btc_timer: 16-bit timer/counter with buffered period and four capture/compare channels.
 * Assumes event inputs synchronous to i_ref_clk, event strobes one cycle long, and a
 * register master that never issues read and write together.
 */
// Operation
// R1 - compare buffer valid set by software write, cleared on update loading active register
// R2 - in capture, buffer valid is set by the capture event
// R3 - capture register and buffer form two-entry queue; transfer sets channel flag
// R4 - active channel registers and buffers readable and writable directly
// R5 - counting up, at top the next counter clock loads zero
// R6 - counting down, at zero the counter reloads with period
// R7 - software counter write wins over count; direction changeable while running
// R8 - event-controlled counting: channel n enables, channel n+1 picks up or down
// R9 - overflow event output can clock another unit through event routing
// R10 - unbuffered period write is immediate; lower period causes wraparound
// R11 - buffered period changes only at update condition
// R12 - event select picks channel A trigger, next channels follow consecutively
// R13 - enabled capture channels store counter value; needs normal operation
// R14 - period below 0x8000: capture msb holds edge polarity, 1 rising
// R15 - input capture sets channel flag; counter cycles zero to top
// R16 - frequency capture: rising event captures and restarts counter
// R17 - pulse width capture: rising restarts, falling captures
// R18 - software enables only one channel in frequency capture
// R19 - event delay bit delays capture events by one clock
// R20 - capture with buffer valid and flag set is dropped, error flag set
// R21 - compare match sets channel flag next clock with event
// R22 - waveform drives pin only with mode, no event action, enabled, output
// R23 - update at bottom or top depending on waveform mode
// R24 - top is period or channel A compare value, per waveform mode
// R25 - after reset no clock selected, counter stopped
// R26 - buffer write coinciding with update loads old value, keeps valid set
`timescale 1ns/100ps
module btc_timer
    import btc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [CNT_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [CNT_W-1:0] o_rdata,
    input wire logic [NEV-1:0] i_ev_strobe,
    input wire logic [NEV-1:0] i_ev_level,
    input wire logic [NCH-1:0] i_pin_dir_out,
    output logic o_ovf_evt,
    output logic o_err_evt,
    output logic [NCH-1:0] o_cc_evt,
    output logic [NCH-1:0] o_wg,
    output logic [NCH-1:0] o_wg_oe
);
    btc_bus_s bus;
    btc_ctrl_s ctrl_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] per_r;
    logic [CNT_W-1:0] period_buffer_r;
    logic perbv_r;
    logic [CNT_W-1:0] cc_r [NCH];
    logic [CNT_W-1:0] ccbuf_r [NCH];
    logic [NCH-1:0] ccbv_r;
    logic [NCH-1:0] ccif_r;
    logic ovf_r;
    logic err_r;
    logic [9:0] pre_r;
    logic [NEV-1:0] evs_d_r;
    logic [NEV-1:0] evl_d_r;
    logic [CNT_W-1:0] rdata_r;
    logic [NCH-1:0] wg_r;
    logic [NCH-1:0] ccevt_r;
    logic ovfevt_r;
    logic errevt_r;

    logic [NEV-1:0] evs;
    logic [NEV-1:0] evl;
    logic tick, count_en, down, at_top, at_bot, wrap, update, capture_mode, restart, status_wr, ds_dir_r;
    logic [CNT_W-1:0] top;
    logic [NCH-1:0] cap_trig, cap_pol, cmp_match, move, overflow, cc_wr, ccbuf_wr, cc_rd;

    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // event inputs, optionally one clock late
    assign evs = ctrl_r.evdly ? evs_d_r : i_ev_strobe; // [R19]
    assign evl = ctrl_r.evdly ? evl_d_r : i_ev_level;

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            evs_d_r <= '0;
            evl_d_r <= '0;
        end else begin
            evs_d_r <= i_ev_strobe;
            evl_d_r <= i_ev_level;
        end
    end

    // common prescaler
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 10'h001;
        end
    end

    // counter clock: off, prescaler tap, or event channel
    always_comb begin
        tick = 1'b0;
        if (ctrl_r.clksel[3]) begin
            tick = evs[ctrl_r.clksel[2:0]]; // [R9]
        end else if (ctrl_r.clksel != CLK_OFF) begin
            tick = (pre_r & PRE_MASK[ctrl_r.clksel[2:0]]) == 10'h000;
        end // [R25]
    end

    assign capture_mode = (ctrl_r.evact == BTC_EA_CAPT) || (ctrl_r.evact == BTC_EA_FRQ) ||
                          (ctrl_r.evact == BTC_EA_PW);

    always_comb begin
        count_en = tick;
        down = ctrl_r.dir_down;
        if (ctrl_r.evact == BTC_EA_UPDOWN) begin
            count_en = tick && evl[ctrl_r.evsel]; // [R8]
            down = !evl[3'(ctrl_r.evsel + 3'h1)]; // [R8]
        end else if (ctrl_r.wgmode == BTC_WG_DS) begin
            down = ds_dir_r;
        end
    end

    assign top = (ctrl_r.wgmode == BTC_WG_FRQ) ? cc_r[0] : per_r; // [R24]
    assign at_top = (cnt_r == top);
    assign at_bot = (cnt_r == 16'h0000);
    assign wrap = count_en && (down ? at_bot : at_top);
    // dual slope updates at bottom only, others at top or bottom turning point
    assign update = (ctrl_r.wgmode == BTC_WG_DS) ? (count_en && at_bot && down) : wrap; // [R23]

    // capture triggers per channel, consecutive event channels
    always_comb begin
        restart = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            cap_trig[i] = 1'b0;
            cap_pol[i] = evl[3'(ctrl_r.evsel + 3'(i))];
            if (ctrl_r.ccen[i] && evs[3'(ctrl_r.evsel + 3'(i))]) begin // [R12]
                case (ctrl_r.evact)
                    BTC_EA_CAPT: cap_trig[i] = 1'b1; // [R15]
                    BTC_EA_FRQ: begin
                        cap_trig[i] = cap_pol[i]; // [R16]
                        restart = restart | cap_pol[i];
                    end
                    BTC_EA_PW: begin
                        cap_trig[i] = !cap_pol[i]; // [R17]
                        restart = restart | cap_pol[i];
                    end
                    default: cap_trig[i] = 1'b0;
                endcase
            end
        end
    end

    // register decode
    assign status_wr = bus.wr && (bus.addr == A_STATUS);
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            cc_wr[i] = bus.wr && (bus.addr == A_CC0 + 5'(i));
            ccbuf_wr[i] = bus.wr && (bus.addr == A_CCBUF0 + 5'(i));
            cc_rd[i] = bus.rd && (bus.addr == A_CC0 + 5'(i));
            cmp_match[i] = count_en && !capture_mode && (cnt_r == cc_r[i]);
            move[i] = capture_mode && ccbv_r[i] && (!ccif_r[i] || cc_rd[i]); // [R3]
            overflow[i] = cap_trig[i] && ccbv_r[i] && ccif_r[i] && !cc_rd[i]; // [R20]
        end
    end

    // control registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            ctrl_r <= '{clksel: CLK_OFF, wgmode: BTC_WG_NORMAL, ccen: '0, evact: BTC_EA_OFF,
                        evdly: 1'b0, evsel: 3'h0, dir_down: 1'b0}; // [R25]
        end else if (bus.wr) begin
            case (bus.addr)
                A_CLKSEL: ctrl_r.clksel <= bus.wdata[3:0];
                A_MODE: begin
                    ctrl_r.wgmode <= btc_wg_e'(bus.wdata[F_WGMODE +: 3]);
                    ctrl_r.ccen <= bus.wdata[F_CCEN +: NCH];
                end
                A_EVCTL: begin
                    ctrl_r.evsel <= bus.wdata[F_EVSEL +: 3];
                    ctrl_r.evdly <= bus.wdata[F_EVDLY];
                    ctrl_r.evact <= btc_evact_e'(bus.wdata[F_EVACT +: 3]);
                end
                A_DIR: ctrl_r.dir_down <= bus.wdata[0]; // [R7]
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    // counter
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            cnt_r <= '0;
        end else if (bus.wr && bus.addr == A_CNT) begin
            cnt_r <= bus.wdata; // [R7]
        end else if (restart) begin
            cnt_r <= '0; // [R16] [R17]
        end else if (count_en) begin
            if (down) begin
                cnt_r <= at_bot ? ((ctrl_r.wgmode == BTC_WG_DS) ? 16'h0001 : top) : cnt_r - 16'h0001; // [R6]
            end else if (at_top) begin
                cnt_r <= (ctrl_r.wgmode == BTC_WG_DS) ? cnt_r - 16'h0001 : 16'h0000; // [R5] [R10]
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // dual slope turning direction
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            ds_dir_r <= 1'b0;
        end else if (restart || ctrl_r.wgmode != BTC_WG_DS) begin
            ds_dir_r <= 1'b0;
        end else if (count_en && at_top && !ds_dir_r) begin
            ds_dir_r <= 1'b1;
        end else if (count_en && at_bot && ds_dir_r) begin
            ds_dir_r <= 1'b0;
        end
    end

    // period and its buffer
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            per_r <= PER_RST;
            period_buffer_r <= PER_RST;
            perbv_r <= 1'b0;
        end else begin
            if (bus.wr && bus.addr == A_PER) begin
                per_r <= bus.wdata; // [R10]
            end else if (update && perbv_r) begin
                per_r <= period_buffer_r; // [R11] [R26]
            end
            if (bus.wr && bus.addr == A_PERIOD_BUFFER) begin
                period_buffer_r <= bus.wdata;
                perbv_r <= 1'b1; // [R1] [R26]
            end else if (update) begin
                perbv_r <= 1'b0; // [R1]
            end
        end
    end

    // channel registers, buffers and flags
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            for (int i = 0; i < NCH; i++) begin
                cc_r[i] <= '0;
                ccbuf_r[i] <= '0;
            end
            ccbv_r <= '0;
            ccif_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (cc_wr[i]) begin
                    cc_r[i] <= bus.wdata; // [R4]
                end else if (move[i]) begin
                    cc_r[i] <= ccbuf_r[i]; // [R3]
                end else if (!capture_mode && update && ccbv_r[i]) begin
                    cc_r[i] <= ccbuf_r[i]; // [R21] [R26]
                end
                if (ccbuf_wr[i]) begin
                    ccbuf_r[i] <= bus.wdata; // [R4]
                    ccbv_r[i] <= !capture_mode; // [R1] [R26]
                end else if (cap_trig[i] && !overflow[i] && (!ccbv_r[i] || move[i])) begin
                    ccbuf_r[i] <= cnt_r; // [R13]
                    if (per_r < POL_LIMIT) begin
                        ccbuf_r[i][CNT_W-1] <= cap_pol[i]; // [R14]
                    end
                    ccbv_r[i] <= 1'b1; // [R2]
                end else if (move[i] || (!capture_mode && update)) begin
                    ccbv_r[i] <= 1'b0; // [R1] [R3]
                end
                if (move[i] || cmp_match[i]) begin
                    ccif_r[i] <= 1'b1; // [R3] [R15] [R21]
                end else if ((status_wr && bus.wdata[S_CCIF + i]) || (capture_mode && cc_rd[i])) begin
                    ccif_r[i] <= 1'b0;
                end
            end
        end
    end

    // overflow and error flags, set wins over clear
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            ovf_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            if (wrap) begin
                ovf_r <= 1'b1;
            end else if (status_wr && bus.wdata[S_OVF]) begin
                ovf_r <= 1'b0;
            end
            if (|overflow) begin
                err_r <= 1'b1; // [R20]
            end else if (status_wr && bus.wdata[S_ERR]) begin
                err_r <= 1'b0;
            end
        end
    end

    // event pulses and waveform
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            ovfevt_r <= 1'b0;
            errevt_r <= 1'b0;
            ccevt_r <= '0;
            wg_r <= '0;
        end else begin
            ovfevt_r <= wrap; // [R9]
            errevt_r <= |overflow;
            ccevt_r <= cmp_match | move; // [R21]
            for (int i = 0; i < NCH; i++) begin
                case (ctrl_r.wgmode)
                    BTC_WG_FRQ: wg_r[i] <= restart ? 1'b0 : (cmp_match[i] ? !wg_r[i] : wg_r[i]);
                    BTC_WG_SS, BTC_WG_DS: wg_r[i] <= (cnt_r < cc_r[i]);
                    default: wg_r[i] <= 1'b0;
                endcase
            end
        end
    end

    // pin override only with waveform mode, no event action, channel on, pin output
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            o_wg_oe[i] = (ctrl_r.wgmode != BTC_WG_NORMAL) && (ctrl_r.evact == BTC_EA_OFF) &&
                         ctrl_r.ccen[i] && i_pin_dir_out[i]; // [R22]
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            rdata_r <= '0;
        end else if (bus.rd) begin
            rdata_r <= '0;
            case (bus.addr)
                A_CLKSEL: rdata_r <= {12'h000, ctrl_r.clksel};
                A_MODE: rdata_r <= {8'h00, ctrl_r.ccen, 1'b0, ctrl_r.wgmode};
                A_EVCTL: rdata_r <= {8'h00, ctrl_r.evact, ctrl_r.evdly, 1'b0, ctrl_r.evsel};
                A_DIR: rdata_r <= {15'h0000, ctrl_r.dir_down};
                A_STATUS: rdata_r <= {5'h00, ccbv_r, perbv_r, ccif_r, err_r, ovf_r};
                A_CNT: rdata_r <= cnt_r;
                A_PER: rdata_r <= per_r;
                A_PERIOD_BUFFER: rdata_r <= period_buffer_r;
                5'h08, 5'h09, 5'h0A, 5'h0B: rdata_r <= cc_r[bus.addr[1:0]]; // [R4]
                5'h0C, 5'h0D, 5'h0E, 5'h0F: rdata_r <= ccbuf_r[bus.addr[1:0]]; // [R4]
                default: rdata_r <= '0;
            endcase
        end else begin
            rdata_r <= '0;
        end
    end

    assign o_rdata = rdata_r;
    assign o_ovf_evt = ovfevt_r;
    assign o_err_evt = errevt_r;
    assign o_cc_evt = ccevt_r;
    assign o_wg = wg_r;
endmodule

// ===== btc_timer_checker.sv
/* btc_timer_checker: port-level assertions for btc_timer, bound to every instance.
   Assumes the btc_pkg register map and a master that never reads and writes together. */
`timescale 1ns/100ps
module btc_timer_checker
    import btc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [CNT_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [CNT_W-1:0] o_rdata,
    input wire logic [NEV-1:0] i_ev_strobe,
    input wire logic [NEV-1:0] i_ev_level,
    input wire logic [NCH-1:0] i_pin_dir_out,
    input wire logic o_ovf_evt,
    input wire logic o_err_evt,
    input wire logic [NCH-1:0] o_cc_evt,
    input wire logic [NCH-1:0] o_wg,
    input wire logic [NCH-1:0] o_wg_oe
);
    logic touched_r;
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            touched_r <= 1'b0;
        end else if (i_wr && (i_addr == A_CLKSEL || i_addr == A_CNT)) begin
            touched_r <= 1'b1;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data not zero outside a read answer");
    AST_UNMAPPED_READ: assert property (i_rd && i_addr[4] |=> o_rdata == 16'h0000)
        else $error("unmapped read returned nonzero");
    AST_CNT_WRITE_WINS: assert property (i_wr && i_addr == A_CNT ##1 i_rd && i_addr == A_CNT
        |=> o_rdata == $past(i_wdata, 2)) else $error("counter write not taken at once");
    AST_PERIOD_BUFFER_HOLD: assert property (i_wr && i_addr == A_PERIOD_BUFFER ##1 i_rd && i_addr == A_PERIOD_BUFFER
        |=> o_rdata == $past(i_wdata, 2)) else $error("period buffer readback wrong");
    AST_STOPPED_AFTER_RESET: assert property (i_rd && i_addr == A_CNT && !touched_r
        |=> o_rdata == 16'h0000) else $error("counter moved without a clock source");
    AST_RESET_QUIET: assert property ($rose(i_nrst) |-> o_rdata == 16'h0000 && !o_ovf_evt
        && !o_err_evt && o_cc_evt == 4'h0 && o_wg == 4'h0 && o_wg_oe == 4'h0)
        else $error("outputs active after reset");
    AST_OE_NEEDS_DIR: assert property ((o_wg_oe & ~i_pin_dir_out) == 4'h0)
        else $error("pin override without output direction");
    AST_OE_STEADY: assert property ($stable(i_pin_dir_out) && !$past(i_wr) |-> $stable(o_wg_oe))
        else $error("pin override changed without a cause");
    COV_OVF: cover property (o_ovf_evt);
    COV_ERR: cover property (o_err_evt);
    COV_CC: cover property (o_cc_evt[0]);
    COV_OE: cover property (o_wg_oe != 4'h0);
endmodule
bind btc_timer btc_timer_checker u_btc_timer_checker (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ev_strobe(i_ev_strobe),
    .i_ev_level(i_ev_level), .i_pin_dir_out(i_pin_dir_out), .o_ovf_evt(o_ovf_evt), .o_err_evt(o_err_evt),
    .o_cc_evt(o_cc_evt), .o_wg(o_wg), .o_wg_oe(o_wg_oe));

// ===== btc_ev_model.sv
/* btc_ev_model: event routing model feeding strobes and levels to the timer.
   Assumes strobes one clock long and levels held until changed. */
`timescale 1ns/100ps
module btc_ev_model
    import btc_pkg::*;
(
    input wire logic i_ref_clk,
    output logic [NEV-1:0] o_ev_strobe,
    output logic [NEV-1:0] o_ev_level
);
    initial begin
        o_ev_strobe = '0;
        o_ev_level = '0;
    end
    // pin edge event, both edges sensed, level gives polarity
    task automatic pulse(input logic [2:0] ch, input logic lvl);
        @(posedge i_ref_clk);
        o_ev_strobe <= 8'h01 << ch;
        o_ev_level[ch] <= lvl;
        @(posedge i_ref_clk);
        o_ev_strobe <= 8'h00;
    endtask
    task automatic set_level(input logic [2:0] ch, input logic lvl);
        @(posedge i_ref_clk);
        o_ev_level[ch] <= lvl;
    endtask
endmodule

// ===== btc_timer_tb_top.sv
/* btc_timer_tb_top: self-checking bench for btc_timer with an event model.
   Assumes the btc_pkg register map and a 200 MHz clock. */
`timescale 1ns/100ps
module btc_timer_tb_top
    import btc_pkg::*;
;
    logic i_ref_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [CNT_W-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [NCH-1:0] i_pin_dir_out = '0;
    logic [NEV-1:0] ev_strobe;
    logic [NEV-1:0] ev_level;
    logic [CNT_W-1:0] o_rdata;
    logic o_ovf_evt;
    logic o_err_evt;
    logic [NCH-1:0] o_cc_evt, o_wg, o_wg_oe, d;
    logic [CNT_W-1:0] last, p, q, b, v1, v2, v3, a1;
    logic saw_ovf = 1'b0;
    logic saw_err = 1'b0;
    logic saw_cc0 = 1'b0;
    logic [2:0] e;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    btc_wg_e wgs[4] = '{BTC_WG_NORMAL, BTC_WG_FRQ, BTC_WG_SS, BTC_WG_DS};
    always #2.5 i_ref_clk = ~i_ref_clk;
    btc_timer u_btc_timer (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ev_strobe(ev_strobe), .i_ev_level(ev_level),
        .i_pin_dir_out(i_pin_dir_out), .o_ovf_evt(o_ovf_evt), .o_err_evt(o_err_evt), .o_cc_evt(o_cc_evt),
        .o_wg(o_wg), .o_wg_oe(o_wg_oe));
    btc_ev_model u_btc_ev_model (.i_ref_clk(i_ref_clk), .o_ev_strobe(ev_strobe), .o_ev_level(ev_level));
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (o_ovf_evt === 1'b1) saw_ovf <= 1'b1;
        if (o_err_evt === 1'b1) saw_err <= 1'b1;
        if (o_cc_evt[0] === 1'b1) saw_cc0 <= 1'b1;
        if (cycles == 20000) begin
            n_fail++;
            conclude();
        end
    end
    function automatic logic [CNT_W-1:0] nxt(input logic [CNT_W-1:0] c, input logic down);
        if (down) return (c == 16'h0000) ? p : c - 16'h0001;
        return (c == p) ? 16'h0000 : c + 16'h0001;
    endfunction
    function automatic logic [CNT_W-1:0] cap_val(input logic [CNT_W-1:0] v, input logic lvl,
        input logic [CNT_W-1:0] per);
        return (per < POL_LIMIT) ? {lvl, v[14:0]} : v;
    endfunction
    task automatic conclude;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [CNT_W-1:0] exp, input logic [CNT_W-1:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input logic w, input logic r, input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] wd);
        @(posedge i_ref_clk);
        i_wr <= w;
        i_rd <= r;
        i_addr <= a;
        i_wdata <= wd;
        #1;
        last = o_rdata;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] wd);
        cyc(1'b1, 1'b0, a, wd);
    endtask
    task automatic idle;
        cyc(1'b0, 1'b0, '0, '0);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        cyc(1'b0, 1'b1, a, '0);
        idle();
    endtask
    task automatic wait_flag(ref logic f, input string what);
        for (int k = 0; k < 300 && f !== 1'b1; k++) begin
            idle();
        end
        chk(what, 16'h0001, {15'h0000, f});
    endtask
    // write the counter, then read it on three consecutive edges
    task automatic cnt_seq(input logic [CNT_W-1:0] start, input logic down);
        logic [CNT_W-1:0] exp;
        exp = start;
        wr(A_CNT, start);
        cyc(1'b0, 1'b1, A_CNT, '0);
        for (int k = 0; k < 3; k++) begin
            cyc(1'b0, k < 2, A_CNT, '0);
            chk("cnt sequence", exp, last);
            exp = nxt(exp, down);
        end
    endtask
    task automatic cap(input logic [CNT_W-1:0] v, input logic lvl);
        wr(A_CNT, v);
        idle();
        u_btc_ev_model.pulse(e, lvl);
    endtask
    initial begin
        void'($urandom(32'hcc07937b));
        repeat (4) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        rd(A_PER); chk("per reset", PER_RST, last);
        rd(A_PERIOD_BUFFER); chk("period_buffer reset", PER_RST, last);
        rd(5'h13); chk("unmapped", 16'h0000, last);
        repeat (20) idle();
        rd(A_CNT); chk("cnt stopped", 16'h0000, last);
        p = 16'h0010 + 16'($urandom_range(63));
        wr(A_PER, p);
        wr(A_CLKSEL, 16'h0001);
        cnt_seq(p - 16'h0001, 1'b0);
        wr(A_DIR, 16'h0001);
        cnt_seq(16'h0001, 1'b1);
        wr(A_DIR, 16'h0000);
        cnt_seq(p + 16'h0005, 1'b0);
        q = 16'h0010 + 16'($urandom_range(63));
        b = 16'($urandom_range(15));
        wr(A_PERIOD_BUFFER, q);
        rd(A_PERIOD_BUFFER); chk("period_buffer", q, last);
        wr(A_CCBUF0, b);
        rd(A_STATUS); chk("bv set", 16'h00C0, last & 16'h00C0);
        rd(A_PER); chk("per held", p, last);
        saw_ovf = 1'b0;
        wr(A_CNT, p - 16'h0002);
        wait_flag(saw_ovf, "overflow");
        repeat (3) idle();
        rd(A_PER); chk("per updated", q, last);
        rd(A_CC0); chk("cc0 updated", b, last);
        rd(A_STATUS); chk("bv cleared", 16'h0000, last & 16'h00C0);
        saw_cc0 = 1'b0;
        wait_flag(saw_cc0, "compare event");
        rd(A_STATUS); chk("ccif", 16'h0004, last & 16'h0004);
        d = 4'($urandom_range(15));
        wr(A_CLKSEL, 16'h0000);
        wr(A_CNT, 16'h0000);
        idle();
        i_pin_dir_out <= d;
        foreach (wgs[i]) begin
            wr(A_MODE, {8'h00, 4'hF, 1'b0, wgs[i]});
            idle();
            chk("wg oe", {12'h000, (wgs[i] == BTC_WG_NORMAL) ? 4'h0 : d}, {12'h000, o_wg_oe});
            idle();
            chk("wg", {15'h0000, wgs[i] > BTC_WG_FRQ && b != 16'h0000}, {12'h000, o_wg});
        end
        e = 3'($urandom_range(7));
        wr(A_EVCTL, {8'h00, BTC_EA_CAPT, 2'b00, 3'(e - 3'h1)});
        idle();
        chk("wg oe capture", 16'h0000, {12'h000, o_wg_oe});
        wr(A_MODE, 16'h00F0);
        wr(A_CLKSEL, 16'h0000);
        wr(A_STATUS, 16'hFFFF);
        v1 = 16'($urandom);
        v2 = 16'($urandom);
        v3 = 16'($urandom);
        cap(v1, 1'b1);
        cap(v2, 1'b0);
        saw_err = 1'b0;
        cap(v3, 1'b1);
        wait_flag(saw_err, "error event");
        rd(A_STATUS); chk("capture flags", 16'h010A, last & 16'h010E);
        rd(A_CC0 + 5'h01); chk("capture 1", cap_val(v1, 1'b1, q), last);
        idle();
        rd(A_CC0 + 5'h01); chk("capture 2", cap_val(v2, 1'b0, q), last);
        wr(A_PER, 16'hFFFF);
        wr(A_MODE, 16'h0010);
        wr(A_EVCTL, {8'h00, BTC_EA_FRQ, 2'b00, e});
        cap(v1, 1'b1);
        rd(A_CNT); chk("freq restart", 16'h0000, last);
        rd(A_CC0); chk("freq capture", cap_val(v1, 1'b1, 16'hFFFF), last);
        wr(A_EVCTL, {8'h00, BTC_EA_PW, 2'b00, e});
        cap(v2, 1'b1);
        rd(A_CNT); chk("pw restart", 16'h0000, last);
        cap(v3, 1'b0);
        rd(A_CC0); chk("pw capture", v3, last);
        wr(A_EVCTL, {8'h00, BTC_EA_UPDOWN, 2'b00, e});
        wr(A_CLKSEL, 16'h0001);
        for (int k = 0; k < 3; k++) begin
            idle();
            u_btc_ev_model.set_level(e, k < 2);
            u_btc_ev_model.set_level(3'(e + 3'h1), k == 0);
            cyc(1'b0, 1'b1, A_CNT, '0);
            cyc(1'b0, 1'b1, A_CNT, '0);
            a1 = last;
            cyc(1'b0, 1'b0, A_CNT, '0);
            chk("updown step", (k == 0) ? 16'h0001 : (k == 1) ? 16'hFFFF : 16'h0000, last - a1);
        end
        conclude();
    end
endmodule
